// ===== asq_pkg.sv
/*
  Constants, register map and state type of the auto sequence step controller.
  Assumes a 100 MHz system clock and a plain strobe register port with 8-bit byte addresses.
*/
`default_nettype none
package asq_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TIME_UNIT_MS = 10; // base tick, 0.01 s
  localparam int TICK_CYCLES = TIME_UNIT_MS * 1000 * CLK_MHZ;
  localparam int RAMP_UNIT_TICKS = 10; // ramp and steady times count in 0.1 s
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_APP_SEL = 8'h00;
  localparam logic [7:0] OFS_AUTO_CFG = 8'h04;
  localparam logic [7:0] OFS_STEP_CNT = 8'h08;
  localparam logic [7:0] OFS_TERM_FN = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_STEP_TBL = 8'h40;
  localparam logic [7:0] OFS_STEP_END = 8'hC0;
  localparam int CFG_TYPE_BIT = 0;
  localparam int CFG_CHECK_LSB = 8;
  localparam int CNT_SEQ2_LSB = 4;
  localparam int WORD_DIR_BIT = 16;
  localparam int WORD_STEADY_LSB = 16;
  // ------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------
  localparam logic [2:0] APP_SEL_RST = 3'h0;
  localparam logic [2:0] APP_AUTO_SEQ = 3'h4;
  localparam logic [7:0] CHECK_RST = 8'h0A;
  localparam logic [3:0] STEPS_RST = 4'h2;
  localparam logic [3:0] MAX_STEPS = 4'h8;
  localparam logic [31:0] TERM_FN_RST = 32'h00000000;
  localparam logic [15:0] FREQ_RST = 16'h044C;
  localparam logic [15:0] RAMP_RST = 16'h0032;
  localparam logic [15:0] STEADY_RST = 16'h0032;
  localparam logic DIR_FWD_RST = 1'b1;
  localparam logic [7:0] FN_SEQ1 = 8'h29;
  localparam logic [7:0] FN_SEQ2 = 8'h2A;
  localparam logic [7:0] FN_MANUAL = 8'h2B;
  localparam logic [7:0] FN_GO_STEP = 8'h2C;
  localparam logic [7:0] FN_HOLD = 8'h2D;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_CHECK = 5'h02,
    ST_RAMP = 5'h04,
    ST_STEADY = 5'h08,
    ST_WAIT_GO = 5'h10
  } asq_state_t;
endpackage
`default_nettype wire

// ===== asq_step_ctrl.sv
/*
  Auto sequence step controller: two stored sequences of up to eight steps, started and
  steered by multi-function terminals, with a strobe register port for settings.
  Assumes terminals and the motor-stopped flag are asynchronous pins; the speed loop
  downstream follows freq_ref_out and dir_fwd_out while run_out is high.
*/
// Overview of operation
// R1 - two independent sequences are stored and either runs on its own once started.
// R2 - a sequence starts only on a rising edge of a terminal assigned a start function.
// R3 - sequencing works only while the application selector holds 4.
// R4 - each step applies its own target frequency, ramp time and direction while active.
// R5 - each sequence runs its own step count, clamped to 1..8, reset value 2.
// R6 - all eight step positions carry the same full set of settings.
// R7 - terminal codes 41, 42, 43, 44, 45 mean start one, start two, manual, advance, hold.
// R8 - while the manual terminal is on the sequencer stands down to the normal sources.
// R9 - type 0 runs all steps alone; type 1 advances per go-step while start stays on.
// R10 - in type 1 a go-step edge while the motor is stopped moves to the next step.
// R11 - in type 0 the hold terminal freezes the steady time of the current step; its ramp still runs.
// R12 - both start terminals within the check window count as asserted together.
// R13 - a step ramps to its target over the ramp time then holds it for the steady time.
`timescale 1ns/10ps
`default_nettype none
module asq_step_ctrl #(
  parameter int NUM_TERM = 4, // at most 4: one code byte each in the terminal register
  parameter int TICK_CYCLES_P = asq_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [asq_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [NUM_TERM-1:0] term_in,
  input wire logic motor_stopped_in,
  output logic run_out,
  output logic dir_fwd_out,
  output logic [15:0] freq_ref_out,
  output logic manual_out,
  output logic step_pulse_out,
  output logic seq_pulse_out,
  output logic active_seq_out,
  output logic [2:0] step_idx_out
);
  import asq_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic term_hit(input logic [31:0] fn, input logic [NUM_TERM-1:0] lvl,
                                    input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_TERM; i++) begin
      hit = hit | (lvl[i] & (fn[8*i +: 8] == code));
    end
    return hit;
  endfunction

  function automatic logic [3:0] clamp_steps(input logic [3:0] v);
    return (v == 4'h0) ? 4'h1 : ((v > MAX_STEPS) ? MAX_STEPS : v);
  endfunction

  function automatic logic [19:0] to_ticks(input logic [15:0] t);
    logic [19:0] n;
    n = 20'(t) * 20'(RAMP_UNIT_TICKS);
    return (n == 20'h00000) ? 20'h00001 : n;
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers and base tick
  // ------------------------------------------------------------
  localparam int PRE_W = $clog2(TICK_CYCLES_P + 1);
  logic [NUM_TERM-1:0] t1_q, t1_d, t2_q, t2_d;
  logic m1_q, m1_d, m2_q, m2_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic tick;

  // first stage feeds only the second stage
  always_comb begin
    t1_d = term_in;
    t2_d = t1_q;
    m1_d = motor_stopped_in;
    m2_d = m1_q;
    tick = (pre_q == PRE_W'(TICK_CYCLES_P - 1));
    pre_d = tick ? '0 : pre_q + PRE_W'(1);
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      t1_q <= '0;
      t2_q <= '0;
      m1_q <= 1'b0;
      m2_q <= 1'b0;
      pre_q <= '0;
    end else begin
      t1_q <= t1_d;
      t2_q <= t2_d;
      m1_q <= m1_d;
      m2_q <= m2_d;
      pre_q <= pre_d;
    end
  end

  // ------------------------------------------------------------
  // register file and step table
  // ------------------------------------------------------------
  logic [2:0] app_q, app_d;
  logic type_q, type_d;
  logic [7:0] check_q, check_d;
  logic [3:0] steps1_q, steps1_d, steps2_q, steps2_d;
  logic [31:0] fn_q, fn_d, rdata_q, rdata_d;
  logic [31:0] tbl_q [32];
  logic [31:0] tbl_d [32];
  logic tbl_sel;
  logic [4:0] tbl_idx;
  asq_state_t state_q, state_d;
  logic run_q, run_d, seq_q, seq_d, conflict_q, conflict_d;
  logic [2:0] step_q, step_d;
  logic [15:0] freq_q, freq_d;

  // table holds seq*16 + step*2 words: even = freq and direction, odd = ramp and steady [R6]
  always_comb begin
    app_d = app_q;
    type_d = type_q;
    check_d = check_q;
    steps1_d = steps1_q;
    steps2_d = steps2_q;
    fn_d = fn_q;
    tbl_d = tbl_q;
    rdata_d = 32'h00000000;
    tbl_sel = (reg_addr_in >= OFS_STEP_TBL) && (reg_addr_in < OFS_STEP_END);
    tbl_idx = 5'((reg_addr_in - OFS_STEP_TBL) >> 2);
    if (reg_wr_in) begin
      if (tbl_sel) begin
        tbl_d[tbl_idx] = reg_wdata_in;
      end else begin
        case (reg_addr_in)
          OFS_APP_SEL: app_d = reg_wdata_in[2:0];
          OFS_AUTO_CFG: begin
            type_d = reg_wdata_in[CFG_TYPE_BIT];
            check_d = reg_wdata_in[CFG_CHECK_LSB +: 8];
          end
          OFS_STEP_CNT: begin
            steps1_d = clamp_steps(reg_wdata_in[3:0]); // [R5]
            steps2_d = clamp_steps(reg_wdata_in[CNT_SEQ2_LSB +: 4]); // [R5]
          end
          OFS_TERM_FN: fn_d = reg_wdata_in;
          default: ;
        endcase
      end
    end
    if (reg_rd_in) begin
      if (tbl_sel) begin
        rdata_d = tbl_q[tbl_idx];
      end else begin
        case (reg_addr_in)
          OFS_APP_SEL: rdata_d = {29'h0, app_q};
          OFS_AUTO_CFG: rdata_d = {16'h0, check_q, 7'h0, type_q};
          OFS_STEP_CNT: rdata_d = {24'h0, steps2_q, steps1_q};
          OFS_TERM_FN: rdata_d = fn_q;
          OFS_STATUS: rdata_d = {freq_q, 3'h0, state_q, 1'b0, conflict_q, manual_out,
                                 step_q, seq_q, run_q};
          default: rdata_d = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      app_q <= APP_SEL_RST;
      type_q <= 1'b0;
      check_q <= CHECK_RST;
      steps1_q <= STEPS_RST;
      steps2_q <= STEPS_RST;
      fn_q <= TERM_FN_RST;
      rdata_q <= 32'h00000000;
      for (int i = 0; i < 32; i++) begin
        tbl_q[i] <= i[0] ? {STEADY_RST, RAMP_RST} : {15'h0, DIR_FWD_RST, FREQ_RST};
      end
    end else begin
      app_q <= app_d;
      type_q <= type_d;
      check_q <= check_d;
      steps1_q <= steps1_d;
      steps2_q <= steps2_d;
      fn_q <= fn_d;
      rdata_q <= rdata_d;
      tbl_q <= tbl_d;
    end
  end
  assign reg_rdata_out = rdata_q;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  logic [19:0] tmr_q, tmr_d, ramp_t, steady_t;
  logic [15:0] start_q, start_d, tgt;
  logic dir_q, dir_d, go_prev_q, s1_prev_q, s2_prev_q;
  logic step_p_q, step_p_d, seq_p_q, seq_p_d;
  logic s1_lvl, s2_lvl, man_lvl, go_lvl, hold_lvl, start_lvl, go_rise, frozen, last;
  logic [31:0] w0, w1;
  logic signed [17:0] diff;
  logic signed [38:0] quo;

  // the divider gives a straight-line ramp; area was traded for an exact end point
  always_comb begin
    s1_lvl = term_hit(fn_q, t2_q, FN_SEQ1); // [R7]
    s2_lvl = term_hit(fn_q, t2_q, FN_SEQ2); // [R7]
    man_lvl = term_hit(fn_q, t2_q, FN_MANUAL); // [R7]
    go_lvl = term_hit(fn_q, t2_q, FN_GO_STEP); // [R7]
    hold_lvl = term_hit(fn_q, t2_q, FN_HOLD); // [R7]
    start_lvl = seq_q ? s2_lvl : s1_lvl;
    go_rise = go_lvl & ~go_prev_q;
    w0 = tbl_q[{seq_q, step_q, 1'b0}]; // [R1]
    w1 = tbl_q[{seq_q, step_q, 1'b1}];
    tgt = w0[15:0];
    ramp_t = to_ticks(w1[15:0]);
    steady_t = to_ticks(w1[WORD_STEADY_LSB +: 16]);
    frozen = ~type_q & hold_lvl; // [R11]
    last = ({1'b0, step_q} == 4'((seq_q ? steps2_q : steps1_q) - 4'h1)); // [R5]
    diff = 18'(signed'({2'b00, tgt})) - 18'(signed'({2'b00, start_q}));
    quo = (39'(diff) * 39'(signed'({1'b0, tmr_q}))) / 39'(signed'({1'b0, ramp_t}));
    state_d = state_q;
    run_d = run_q;
    seq_d = seq_q;
    step_d = step_q;
    tmr_d = tmr_q;
    start_d = start_q;
    freq_d = freq_q;
    conflict_d = conflict_q;
    step_p_d = 1'b0;
    seq_p_d = 1'b0;
    if ((app_q != APP_AUTO_SEQ) || man_lvl || (type_q && !start_lvl && run_q)) begin
      state_d = ST_IDLE; // [R3] [R8] [R9]
      run_d = 1'b0;
      freq_d = 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if ((s1_lvl && !s1_prev_q) || (s2_lvl && !s2_prev_q)) begin
            state_d = ST_CHECK; // [R2]
            seq_d = s2_lvl & ~s1_lvl;
            tmr_d = 20'h00000;
            conflict_d = 1'b0;
          end
        end
        ST_CHECK: begin
          tmr_d = tmr_q + 20'(tick);
          if (s1_lvl && s2_lvl) begin
            state_d = ST_IDLE; // [R12]
            conflict_d = 1'b1;
          end else if (tmr_q >= 20'(check_q)) begin
            state_d = start_lvl ? ST_RAMP : ST_IDLE; // [R2]
            run_d = start_lvl;
            step_d = 3'h0;
            tmr_d = 20'h00000;
            start_d = freq_q;
          end
        end
        ST_RAMP: begin
          tmr_d = tmr_q + 20'(tick);
          freq_d = 16'(signed'({2'b00, start_q}) + quo[17:0]); // [R13]
          if (tmr_q >= ramp_t) begin
            state_d = ST_STEADY;
            tmr_d = 20'h00000;
            freq_d = tgt; // [R4]
          end
        end
        ST_STEADY: begin
          freq_d = tgt;
          tmr_d = frozen ? tmr_q : tmr_q + 20'(tick); // [R11]
          if (!frozen && tmr_q >= steady_t) begin
            tmr_d = 20'h00000;
            if (last) begin
              state_d = ST_IDLE;
              run_d = 1'b0;
              freq_d = 16'h0000;
              seq_p_d = 1'b1;
            end else if (type_q) begin
              state_d = ST_WAIT_GO; // [R9]
            end else begin
              state_d = ST_RAMP; // [R9]
              step_d = step_q + 3'h1;
              start_d = tgt;
              step_p_d = 1'b1;
            end
          end
        end
        ST_WAIT_GO: begin
          if (go_rise && m2_q) begin
            state_d = ST_RAMP; // [R10]
            step_d = step_q + 3'h1;
            tmr_d = 20'h00000;
            start_d = freq_q;
            step_p_d = 1'b1;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
    // direction follows the step being entered, so it never lags the step index by a cycle
    dir_d = tbl_q[{seq_d, step_d, 1'b0}][WORD_DIR_BIT]; // [R4]
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      run_q <= 1'b0;
      seq_q <= 1'b0;
      step_q <= 3'h0;
      tmr_q <= 20'h00000;
      start_q <= 16'h0000;
      freq_q <= 16'h0000;
      dir_q <= DIR_FWD_RST;
      conflict_q <= 1'b0;
      step_p_q <= 1'b0;
      seq_p_q <= 1'b0;
      go_prev_q <= 1'b0;
      s1_prev_q <= 1'b0;
      s2_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      run_q <= run_d;
      seq_q <= seq_d;
      step_q <= step_d;
      tmr_q <= tmr_d;
      start_q <= start_d;
      freq_q <= freq_d;
      dir_q <= dir_d;
      conflict_q <= conflict_d;
      step_p_q <= step_p_d;
      seq_p_q <= seq_p_d;
      go_prev_q <= go_lvl;
      s1_prev_q <= s1_lvl;
      s2_prev_q <= s2_lvl;
    end
  end

  assign run_out = run_q;
  assign dir_fwd_out = dir_q;
  assign freq_ref_out = freq_q;
  assign manual_out = man_lvl;
  assign step_pulse_out = step_p_q;
  assign seq_pulse_out = seq_p_q;
  assign active_seq_out = seq_q;
  assign step_idx_out = step_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  app_gate_a: assert property ((app_q != APP_AUTO_SEQ) |=> !run_q) // [R3]
    else $error("sequencer ran with the selector not at auto sequence");
  manual_idle_a: assert property (man_lvl |=> (state_q == ST_IDLE) && !run_q) // [R8]
    else $error("manual terminal did not stop the sequencer");
  step_bound_a: assert property (run_q |-> (4'(step_q) < (seq_q ? steps2_q : steps1_q))) // [R5]
    else $error("step index beyond the step count");
  start_cause_a: assert property ($rose(run_q) |-> $past(state_q) == ST_CHECK) // [R2]
    else $error("run began without a start terminal");
  hold_freeze_a: assert property ((state_q == ST_STEADY && frozen && run_d) |=> $stable(tmr_q)) // [R11]
    else $error("hold terminal did not freeze the step");
  go_step_a: assert property ((state_q == ST_WAIT_GO && go_rise && m2_q && run_d)
                              |=> step_p_q && state_q == ST_RAMP) // [R10]
    else $error("go-step with motor stopped did not advance");
  steady_freq_a: assert property ((state_q == ST_STEADY) |-> freq_q == tgt) // [R13]
    else $error("steady phase not at the step target");
  both_start_a: assert property ((state_q == ST_CHECK && s1_lvl && s2_lvl && run_d == run_q
                                 && app_q == APP_AUTO_SEQ && !man_lvl)
                                 |=> conflict_q && state_q == ST_IDLE ##1 !run_q) // [R12]
    else $error("simultaneous start not recognised");
  seq_end_a: assert property (seq_p_q |-> !run_q && $past(state_q) == ST_STEADY) // [R9]
    else $error("sequence end pulse outside the last step");
endmodule
`default_nettype wire

// ===== asq_far_model.sv
/*
  Far-side model of the auto sequence step controller: terminal wiring and the motor.
  Assumes the bench calls put and brake from its own process right after a clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module asq_far_model (
  input wire logic sys_clk_in,
  input wire logic [15:0] freq_ref_in,
  output logic [3:0] term_out,
  output logic motor_stopped_out
);
  logic [3:0] term_q;
  logic brake_q;
  // ------------------------------------------------------------
  // terminal and motor behaviour
  // ------------------------------------------------------------
  initial begin
    term_q = 4'h0;
    brake_q = 1'b0;
  end
  // sequences start only from a terminal level change driven here
  task automatic put(input logic [3:0] lv);
    @(posedge sys_clk_in);
    term_q <= lv;
  endtask
  // an operator stop; the motor also rests whenever the reference is zero
  task automatic brake(input logic v);
    @(posedge sys_clk_in);
    brake_q <= v;
  endtask
  assign term_out = term_q;
  assign motor_stopped_out = brake_q | (freq_ref_in == 16'h0000);
endmodule
`default_nettype wire

// ===== tb.sv
/*
  Self-checking bench for the auto sequence step controller, with a short base tick.
  Assumes asq_pkg and asq_far_model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import asq_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h00000000;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out;
  logic [3:0] term;
  logic motor_stopped;
  logic run_out, dir_fwd_out, manual_out, step_pulse_out, seq_pulse_out, active_seq_out;
  logic [15:0] freq_ref_out;
  logic [2:0] step_idx_out;
  logic [31:0] rv;
  int n_errors = 0;
  int samples_checked = 0;
  // ------------------------------------------------------------
  // clock, design and far side
  // ------------------------------------------------------------
  always #5 sys_clk_in = ~sys_clk_in;
  // a 4-cycle tick keeps ramps and windows to tens of cycles
  asq_step_ctrl #(.TICK_CYCLES_P(4)) i_dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .term_in(term), .motor_stopped_in(motor_stopped),
    .run_out(run_out), .dir_fwd_out(dir_fwd_out), .freq_ref_out(freq_ref_out),
    .manual_out(manual_out), .step_pulse_out(step_pulse_out), .seq_pulse_out(seq_pulse_out),
    .active_seq_out(active_seq_out), .step_idx_out(step_idx_out));
  asq_far_model i_far (.sys_clk_in(sys_clk_in), .freq_ref_in(freq_ref_out),
    .term_out(term), .motor_stopped_out(motor_stopped));
  // ------------------------------------------------------------
  // bus cycles, comparison and closing
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(nm, d, exp);
  endtask
  // pulses last one cycle, so every cycle is looked at; a timeout is a mismatch
  task automatic wait_ev(input int sel, input logic v, input int lim);
    logic s;
    int k;
    s = ~v;
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge sys_clk_in);
      #1 s = (sel == 0) ? run_out : (sel == 1) ? step_pulse_out : seq_pulse_out;
      k++;
    end
    chk("event", {31'h0, s}, {31'h0, v});
  endtask
  task automatic end_sim;
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    n_errors++;
    end_sim();
  end
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    // reset values
    rchk("app", OFS_APP_SEL, 32'h00000000);
    rchk("cfg", OFS_AUTO_CFG, {16'h0000, CHECK_RST, 8'h00});
    rchk("cnt", OFS_STEP_CNT, {24'h000000, STEPS_RST, STEPS_RST});
    rchk("tfn", OFS_TERM_FN, TERM_FN_RST);
    rchk("tbl0", OFS_STEP_TBL, {15'h0000, DIR_FWD_RST, FREQ_RST});
    rchk("tbl7", 8'hBC, {STEADY_RST, RAMP_RST});
    rchk("unmapped", 8'hFC, 32'h00000000);
    // counts of 0 and 9 are held to the legal range
    wr(OFS_STEP_CNT, 32'h00000090);
    rchk("clamp", OFS_STEP_CNT, 32'h00000081);
    // two steps in sequence one, one in sequence two, short times
    wr(OFS_STEP_CNT, 32'h00000012);
    wr(OFS_AUTO_CFG, 32'h00000200);
    wr(OFS_TERM_FN, {FN_HOLD, FN_MANUAL, FN_SEQ2, FN_SEQ1});
    wr(8'h40, 32'h00000100);
    wr(8'h44, 32'h00010001);
    wr(8'h48, 32'h00010200);
    wr(8'h4C, 32'h00010001);
    wr(8'h80, 32'h00010300);
    wr(8'h84, 32'h00010001);
    wr(OFS_APP_SEL, 32'h00000004);
    #1 chk("idle run", {31'h0, run_out}, 32'h0);
    // sequence one, type 0, runs both steps alone
    i_far.put(4'b0001);
    wait_ev(0, 1'b1, 100);
    chk("seq", {31'h0, active_seq_out}, 32'h0);
    chk("dir0", {31'h0, dir_fwd_out}, 32'h0);
    repeat (60) @(posedge sys_clk_in);
    #1 chk("freq0", {16'h0, freq_ref_out}, 32'h00000100);
    wait_ev(1, 1'b1, 100);
    chk("step1", {29'h0, step_idx_out}, 32'h1);
    chk("dir1", {31'h0, dir_fwd_out}, 32'h1);
    // midway through the ramp the reference lies strictly between the two step targets
    repeat (20) @(posedge sys_clk_in);
    #1 chk("ramp mid", {31'h0, (freq_ref_out > 16'h0100) && (freq_ref_out < 16'h0200)}, 32'h1);
    wait_ev(2, 1'b1, 200);
    @(posedge sys_clk_in);
    #1 chk("end run", {31'h0, run_out}, 32'h0);
    chk("end freq", {16'h0, freq_ref_out}, 32'h0);
    i_far.put(4'b0000);
    // manual terminal takes over mid-run
    repeat (5) @(posedge sys_clk_in);
    i_far.put(4'b0001);
    wait_ev(0, 1'b1, 100);
    i_far.put(4'b0101);
    wait_ev(0, 1'b0, 10);
    chk("manual", {31'h0, manual_out}, 32'h1);
    chk("man freq", {16'h0, freq_ref_out}, 32'h0);
    i_far.put(4'b0000);
    // sequence two with the hold terminal on
    repeat (5) @(posedge sys_clk_in);
    i_far.put(4'b1000);
    i_far.put(4'b1010);
    wait_ev(0, 1'b1, 100);
    chk("seq2", {31'h0, active_seq_out}, 32'h1);
    repeat (150) @(posedge sys_clk_in);
    #1 chk("hold run", {31'h0, run_out}, 32'h1);
    chk("hold freq", {16'h0, freq_ref_out}, 32'h00000300);
    i_far.put(4'b0010);
    wait_ev(2, 1'b1, 100);
    i_far.put(4'b0000);
    // both starts together are refused and flagged
    repeat (5) @(posedge sys_clk_in);
    i_far.put(4'b0011);
    repeat (40) @(posedge sys_clk_in);
    #1 chk("both run", {31'h0, run_out}, 32'h0);
    rd(OFS_STATUS, rv);
    chk("both flag", {31'h0, rv[6]}, 32'h1);
    i_far.put(4'b0000);
    // type 1: steps advance only on go-step with the motor stopped
    wr(OFS_AUTO_CFG, 32'h00000201);
    wr(OFS_TERM_FN, {FN_GO_STEP, FN_MANUAL, FN_SEQ2, FN_SEQ1});
    i_far.put(4'b0001);
    wait_ev(0, 1'b1, 100);
    repeat (120) @(posedge sys_clk_in);
    #1 chk("wait run", {31'h0, run_out}, 32'h1);
    chk("wait step", {29'h0, step_idx_out}, 32'h0);
    i_far.brake(1'b1);
    i_far.put(4'b1001);
    wait_ev(1, 1'b1, 20);
    chk("go step", {29'h0, step_idx_out}, 32'h1);
    i_far.put(4'b0000);
    i_far.brake(1'b0);
    wait_ev(0, 1'b0, 10);
    // a selector other than 4 keeps sequencing off
    wr(OFS_APP_SEL, 32'h00000003);
    i_far.put(4'b0001);
    repeat (40) @(posedge sys_clk_in);
    #1 chk("app off", {31'h0, run_out}, 32'h0);
    i_far.put(4'b0000);
    end_sim();
  end
endmodule
`default_nettype wire
